/* File: shared/dregsp_pkg.sv */
// Functional notes
// R1 - Address is 00010 plus two strap bits.
// R2 - Seven address bits MSB first, direction, acknowledge.
// R3 - Write byte: two select bits, six payload.
// R4 - Reads alternate status one, two; restart one.
// R5 - Start or stop inside transfer resets sequencing.
// R6 - Master changes data only while clock low.
// R7 - Master writes one control byte per transfer.
// R8 - Matching address is acknowledged on ninth clock.
// R9 - Written byte acknowledged; master releases data line.
// R10 - Read sends byte, releases line for acknowledge.
// R11 - Master acknowledge continues; no acknowledge stops.
// R12 - Attention line is active low open drain.
// R13 - Attention set on new fault and power-on.
// R14 - Attention cleared after read address acknowledged.
// R15 - Fault flags are latched in status.
// R16 - Non-fault flags never raise attention.
// R17 - Live flags follow conditions; off flag on changes.
// R18 - Status held until read completes, then resampled.
// R19 - Healthy device reads all-zero status.
// R20 - Bus ignored until logic supply ready; undervoltage set.
// R21 - Control registers are zero after power-up.
// R22 - Select 00 channel one, 01 channel two.
// R23 - Bits 0-2 step, 3 range, 5 output enable.
// R24 - Bit 4 is stored but has no effect.
// R25 - Select 10/11 tone registers: source, gate, cable test.
// R26 - Unmatched address: no acknowledge, ignore until start.
`default_nettype none

package dregsp_pkg;

    localparam logic [4:0] ADDR_FIXED_HI = 5'h02;

    localparam logic [1:0] SEL_CHAN1_OUTPUT = 2'h0;
    localparam logic [1:0] SEL_CHAN2_OUTPUT = 2'h1;
    localparam logic [1:0] SEL_CHAN1_TONE   = 2'h2;
    localparam logic [1:0] SEL_CHAN2_TONE   = 2'h3;

    // Field positions inside an output-setting register.
    localparam int LEVEL_STEP_BIT0       = 0;
    localparam int LEVEL_RANGE_BIT       = 3;
    localparam int OVERCURRENT_TIMER_BIT = 4;
    localparam int OUTPUT_ON_BIT         = 5;
    // Field positions inside a tone register.
    localparam int TONE_SOURCE_BIT = 0;
    localparam int TONE_ON_BIT     = 1;
    localparam int CABLE_TEST_BIT  = 2;

    localparam logic [5:0] OUTPUT_SETTING_RESET = 6'h00;
    localparam logic [2:0] TONE_SETTING_RESET   = 3'h0;

    // Latched fault vector, status register one bits 3..0.
    localparam int FLT_OVERTEMP     = 0;
    localparam int FLT_UNDERVOLTAGE = 1;
    localparam int FLT_OVERCURRENT1 = 2;
    localparam int FLT_OVERCURRENT2 = 3;
    localparam int FAULT_W          = 4;
    // Live vector: bits 3..0 go to status one 7..4, 7..4 to status two.
    localparam int LIVE_OFF1   = 0;
    localparam int LIVE_OFF2   = 1;
    localparam int LIVE_PNG1   = 2;
    localparam int LIVE_PNG2   = 3;
    localparam int LIVE_CAD1   = 4;
    localparam int LIVE_CAD2   = 5;
    localparam int LIVE_TONE1  = 6;
    localparam int LIVE_TONE2  = 7;
    localparam int LIVE_W      = 8;

    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT  = 4'h7;
    localparam int         PIN_W     = 17;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK,
        ST_SKIP
    } dregsp_state_e;

endpackage

`default_nettype wire

/* File: rtl/dregsp_sync.sv */
`default_nettype none

module dregsp_sync
    import dregsp_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } dregsp_sync_s;

    dregsp_sync_s s;
    dregsp_sync_s next_s;

    always_comb begin
        next_s.first  = i_async;
        next_s.second = s.first;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_sync = s.second;

endmodule

`default_nettype wire

/* File: rtl/dregsp_status.sv */
`default_nettype none

module dregsp_status
    import dregsp_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_reset_n,
    input  wire logic [FAULT_W-1:0] i_fault_raw,
    input  wire logic [LIVE_W-1:0]  i_live_raw,
    input  wire logic               i_freeze,
    input  wire logic               i_resample,
    input  wire logic               i_por,
    output logic      [7:0]         o_status1,
    output logic      [7:0]         o_status2,
    output logic                    o_fault_new
);

    typedef struct packed {
        logic [FAULT_W-1:0] fault_lat;
        logic [FAULT_W-1:0] pend;
        logic [LIVE_W-1:0]  live;
        logic               fault_new;
    } dregsp_status_s;

    dregsp_status_s s;
    dregsp_status_s next_s;

    always_comb begin
        next_s = s;
        // R13 first recognition pulse
        next_s.fault_new = |(i_fault_raw & ~s.fault_lat & ~s.pend);
        if (i_resample) begin
            // R18 resample after read
            next_s.fault_lat = i_fault_raw | s.pend;
            next_s.pend      = '0;
            next_s.live      = i_live_raw;
        end else if (i_freeze) begin
            // Faults seen during a read wait here so the byte stays stable.
            next_s.pend = s.pend | i_fault_raw;
        end else begin
            // R15 latch fault bits
            next_s.fault_lat = s.fault_lat | i_fault_raw | s.pend;
            next_s.pend      = '0;
            // R17 live flags follow
            next_s.live      = i_live_raw;
        end
        // R20 power-on undervoltage set
        if (i_por) begin
            next_s.fault_lat[FLT_UNDERVOLTAGE] = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // R19 zero when healthy
    assign o_status1   = {s.live[3:0], s.fault_lat};
    assign o_status2   = {4'h0, s.live[7:4]};
    assign o_fault_new = s.fault_new;

    status_hold_a: assert property ( // R18
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_freeze && !i_resample && !i_por) |=> ($stable(o_status1)
            && $stable(o_status2)))
        else $error("Status changed during a read transfer.");

endmodule

`default_nettype wire

/* File: rtl/dregsp_port.sv */
`default_nettype none

module dregsp_port
    import dregsp_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [1:0] i_bus_id_pin,
    input  wire logic       i_logic_supply_ok,
    input  wire logic       i_main_supply_ok,
    input  wire logic       i_overtemp,
    input  wire logic [1:0] i_overcurrent,
    input  wire logic [1:0] i_output_off,
    input  wire logic [1:0] i_power_not_good,
    input  wire logic [1:0] i_cable_disconnect,
    input  wire logic [1:0] i_tone_present,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    output logic            o_attention_line_n_out,
    output logic            o_attention_line_n_oe,
    output logic      [5:0] o_chan1_output_setting,
    output logic      [5:0] o_chan2_output_setting,
    output logic      [2:0] o_chan1_tone_setting,
    output logic      [2:0] o_chan2_tone_setting
);

    typedef struct packed {
        dregsp_state_e state;
        logic          scl_d;
        logic          sda_d;
        logic [3:0]    bitcnt;
        logic [7:0]    shift;
        logic          rw;
        logic          rd_sel;
        logic          rd_acked;
        logic          in_read;
        logic          sda_oe;
        logic          attn_oe;
        logic          por_done;
        logic [5:0]    chan1_out;
        logic [5:0]    chan2_out;
        logic [2:0]    chan1_tone;
        logic [2:0]    chan2_tone;
    } dregsp_port_s;

    dregsp_port_s s;
    dregsp_port_s next_s;

    logic [PIN_W-1:0]   pins;
    logic [PIN_W-1:0]   sy;
    logic [7:0]         status1;
    logic [7:0]         status2;
    logic               fault_new;
    logic [FAULT_W-1:0] fault_raw;
    logic [LIVE_W-1:0]  live_raw;
    logic               scl;
    logic               sda;
    logic               ready;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_det;
    logic               stop_det;
    logic               por_evt;
    logic               attn_clear;
    logic               resample;
    logic [6:0]         own_addr;
    logic [7:0]         next_byte;

    assign pins = {i_tone_present, i_cable_disconnect, i_power_not_good,
                   i_output_off, i_overcurrent, i_overtemp,
                   i_main_supply_ok, i_logic_supply_ok, i_bus_id_pin,
                   i_sda, i_scl};

    dregsp_sync #(
        .WIDTH (PIN_W)
    ) u_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_async   (pins),
        .o_sync    (sy)
    );

    assign scl   = sy[0];
    assign sda   = sy[1];
    assign ready = sy[4];
    // R1 strap selects address
    assign own_addr  = {ADDR_FIXED_HI, sy[3:2]};
    // R16 faults only, no live flags
    assign fault_raw = {sy[8:7], ~sy[5], sy[6]};
    assign live_raw  = {sy[16:15], sy[14:13], sy[12:11], sy[10:9]};

    assign scl_rise  = scl & ~s.scl_d;
    assign scl_fall  = ~scl & s.scl_d;
    // R6 data edges with clock high mark frames
    assign start_det = scl & s.scl_d & s.sda_d & ~sda;
    assign stop_det  = scl & s.scl_d & ~s.sda_d & sda;
    // R13 power-on raises attention
    assign por_evt   = ready & sy[5] & ~s.por_done;

    dregsp_status u_status (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_fault_raw (fault_raw),
        .i_live_raw  (live_raw),
        .i_freeze    (s.in_read),
        .i_resample  (resample),
        .i_por       (por_evt),
        .o_status1   (status1),
        .o_status2   (status2),
        .o_fault_new (fault_new)
    );

    always_comb begin
        next_s     = s;
        resample   = 1'b0;
        attn_clear = 1'b0;
        next_byte  = s.rd_sel ? status2 : status1;
        next_s.scl_d = scl;
        next_s.sda_d = sda;
        if (!ready) begin
            // R20 bus ignored before supply
            next_s.state    = ST_IDLE;
            next_s.sda_oe   = 1'b0;
            next_s.in_read  = 1'b0;
            next_s.por_done = 1'b0;
        end else if (start_det || stop_det) begin
            // R5 frame edge resets sequence
            resample       = s.in_read;
            next_s.in_read = 1'b0;
            next_s.sda_oe  = 1'b0;
            next_s.bitcnt  = 4'h0;
            next_s.state   = start_det ? ST_ADDR : ST_IDLE;
        end else begin
            case (s.state)
                ST_ADDR, ST_WR_DATA: begin
                    if (scl_rise) begin
                        // R2 shift in MSB first
                        next_s.shift  = {s.shift[6:0], sda};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (scl_fall && s.bitcnt == BYTE_BITS) begin
                        next_s.bitcnt = 4'h0;
                        if (s.state == ST_ADDR) begin
                            if (s.shift[7:1] == own_addr) begin
                                // R8 acknowledge own address
                                next_s.sda_oe = 1'b1;
                                next_s.rw     = s.shift[0];
                                next_s.state  = ST_ADDR_ACK;
                            end else begin
                                // R26 foreign address ignored
                                next_s.state = ST_SKIP;
                            end
                        end else begin
                            // R3 select and payload split
                            case (s.shift[7:6])
                                // R22 output setting targets
                                SEL_CHAN1_OUTPUT: begin
                                    next_s.chan1_out = s.shift[5:0];
                                end
                                SEL_CHAN2_OUTPUT: begin
                                    next_s.chan2_out = s.shift[5:0];
                                end
                                // R25 tone register targets
                                SEL_CHAN1_TONE: begin
                                    next_s.chan1_tone = s.shift[2:0];
                                end
                                default: begin
                                    next_s.chan2_tone = s.shift[2:0];
                                end
                            endcase
                            // R9 acknowledge written byte
                            next_s.sda_oe = 1'b1;
                            next_s.state  = ST_WR_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (s.rw) begin
                            // R4 read begins with status one
                            next_s.in_read = 1'b1;
                            next_s.rd_sel  = 1'b1;
                            next_s.shift   = status1;
                            next_s.sda_oe  = ~status1[7];
                            next_s.state   = ST_RD_DATA;
                            attn_clear     = 1'b1;
                        end else begin
                            next_s.sda_oe = 1'b0;
                            next_s.state  = ST_WR_DATA;
                        end
                    end
                end
                ST_WR_ACK: begin
                    // R7 further bytes are not taken
                    if (scl_fall) begin
                        next_s.sda_oe = 1'b0;
                        next_s.state  = ST_SKIP;
                    end
                end
                ST_RD_DATA: begin
                    if (scl_fall) begin
                        if (s.bitcnt == LAST_BIT) begin
                            // R10 release for master acknowledge
                            next_s.sda_oe = 1'b0;
                            next_s.bitcnt = 4'h0;
                            next_s.state  = ST_RD_ACK;
                        end else begin
                            next_s.bitcnt = s.bitcnt + 4'h1;
                            next_s.shift  = {s.shift[6:0], 1'b0};
                            next_s.sda_oe = ~s.shift[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        next_s.rd_acked = ~sda;
                    end else if (scl_fall) begin
                        if (s.rd_acked) begin
                            // R11 acknowledged, send alternate byte
                            next_s.shift  = next_byte;
                            next_s.sda_oe = ~next_byte[7];
                            next_s.rd_sel = ~s.rd_sel;
                            next_s.state  = ST_RD_DATA;
                        end else begin
                            next_s.state = ST_SKIP;
                        end
                    end
                end
                default: begin
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end
        if (ready) begin
            next_s.por_done = s.por_done | por_evt;
        end
        // R14 attention clear, set wins
        if (fault_new || por_evt) begin
            next_s.attn_oe = 1'b1;
        end else if (attn_clear) begin
            next_s.attn_oe = 1'b0;
        end
    end

    // R21 controls zero at reset
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Both open-drain pins only ever pull low; the enable carries the data.
    assign o_sda_out              = 1'b0;
    assign o_sda_oe               = s.sda_oe;
    // R12 open-drain active-low attention
    assign o_attention_line_n_out = 1'b0;
    assign o_attention_line_n_oe  = s.attn_oe;
    // R23 R24 fields pass straight to the regulators
    assign o_chan1_output_setting = s.chan1_out;
    assign o_chan2_output_setting = s.chan2_out;
    assign o_chan1_tone_setting   = s.chan1_tone;
    assign o_chan2_tone_setting   = s.chan2_tone;

    start_reset_a: assert property ( // R5
        @(posedge i_clk) disable iff (!i_reset_n)
        (ready && start_det) |=> (s.state == ST_ADDR && s.bitcnt == 4'h0
            && !s.sda_oe))
        else $error("Start did not restart the address phase.");

    stop_reset_a: assert property ( // R5
        @(posedge i_clk) disable iff (!i_reset_n)
        (ready && stop_det) |=> (s.state == ST_IDLE && !s.in_read))
        else $error("Stop did not end the transfer.");

    addr_ack_a: assert property ( // R8
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(s.state == ST_ADDR_ACK) |->
            ($past(s.shift[7:1]) == own_addr && s.sda_oe))
        else $error("Address acknowledge without a match.");

    foreign_quiet_a: assert property ( // R26
        @(posedge i_clk) disable iff (!i_reset_n)
        (s.state == ST_SKIP) |-> !s.sda_oe)
        else $error("Data line driven while ignoring a transfer.");

    rd_release_a: assert property ( // R10
        @(posedge i_clk) disable iff (!i_reset_n)
        (s.state == ST_RD_ACK) |-> !s.sda_oe)
        else $error("Data line held during master acknowledge.");

    attn_set_a: assert property ( // R13
        @(posedge i_clk) disable iff (!i_reset_n)
        (fault_new || por_evt) |=> o_attention_line_n_oe
            ##1 (o_attention_line_n_oe || $past(attn_clear)))
        else $error("Attention not raised on a new fault.");

    attn_cause_a: assert property ( // R16
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_attention_line_n_oe) |-> $past(fault_new || por_evt))
        else $error("Attention raised without a fault or power-on.");

    attn_clear_a: assert property ( // R14
        @(posedge i_clk) disable iff (!i_reset_n)
        $fell(o_attention_line_n_oe) |->
            ($past(s.state) == ST_ADDR_ACK && s.state == ST_RD_DATA))
        else $error("Attention cleared outside a read address.");

    ctrl_write_a: assert property ( // R3
        @(posedge i_clk) disable iff (!i_reset_n)
        (ready && !start_det && !stop_det && s.state == ST_WR_DATA
            && scl_fall && s.bitcnt == BYTE_BITS
            && s.shift[7:6] == SEL_CHAN1_OUTPUT)
        |=> (s.chan1_out == $past(s.shift[5:0]) && s.state == ST_WR_ACK))
        else $error("Control byte not stored in channel one.");

    power_ignore_a: assert property ( // R20
        @(posedge i_clk) disable iff (!i_reset_n)
        !ready |=> (s.state == ST_IDLE && !s.sda_oe))
        else $error("Bus served before logic supply is ready.");

endmodule

`default_nettype wire

/* File: dv/dregsp_master.sv */
`default_nettype none

module dregsp_master (
    input  wire logic i_clk,
    input  wire logic i_sda_oe,
    output logic      o_scl,
    output logic      o_sda
);
    timeunit 1ns;
    timeprecision 1ps;

    logic pull;

    // The data wire has a pull-up, so a released line reads high.
    assign o_sda = ~(pull | i_sda_oe);

    initial begin
        pull  = 1'b0;
        o_scl = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic start();
        pull = 1'b0;
        // Clock stays low until a released acknowledge has settled.
        tick(6);
        o_scl = 1'b1;
        tick(4);
        pull = 1'b1;
        tick(4);
        o_scl = 1'b0;
    endtask

    task automatic stop();
        tick(1);
        pull = 1'b1;
        tick(5);
        o_scl = 1'b1;
        tick(4);
        pull = 1'b0;
        tick(4);
    endtask

    // bits leave top first, data moved only with clock low
    task automatic xfer9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            tick(1);
            pull = ~tx[i];
            tick(5);
            o_scl = 1'b1;
            tick(2);
            rx[i] = o_sda;
            o_scl = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

/* File: dv/dual_regulator_serial_ctrl_port_tb.sv */
`default_nettype none

module dual_regulator_serial_ctrl_port_tb
    import dregsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, reset_n, scl, sda, sda_oe, logic_ok, main_ok, ot;
    logic        ack, att_out, att_oe, sda_out;
    logic [1:0]  bus_id, overcurrent_flag, off, power_not_good_flag, cad, tone, ak;
    logic [5:0]  ch1, ch2;
    logic [2:0]  t1, t2;
    logic [8:0]  rx;
    logic [7:0]  d;
    logic [6:0]  addr;
    logic [31:0] seed;
    logic [7:0]  rb [3];
    logic [5:0]  st [4];
    int          n_fail, checks_done;

    dregsp_port u_dut (
        .i_clk                  (clk),
        .i_reset_n              (reset_n),
        .i_scl                  (scl),
        .i_sda                  (sda),
        .i_bus_id_pin           (bus_id),
        .i_logic_supply_ok      (logic_ok),
        .i_main_supply_ok       (main_ok),
        .i_overtemp             (ot),
        .i_overcurrent          (overcurrent_flag),
        .i_output_off           (off),
        .i_power_not_good       (power_not_good_flag),
        .i_cable_disconnect     (cad),
        .i_tone_present         (tone),
        .o_sda_out              (sda_out),
        .o_sda_oe               (sda_oe),
        .o_attention_line_n_out (att_out),
        .o_attention_line_n_oe  (att_oe),
        .o_chan1_output_setting (ch1),
        .o_chan2_output_setting (ch2),
        .o_chan1_tone_setting   (t1),
        .o_chan2_tone_setting   (t2)
    );

    dregsp_master u_master (
        .i_clk    (clk),
        .i_sda_oe (sda_oe),
        .o_scl    (scl),
        .o_sda    (sda)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] exp_s1(input logic uv, input logic t);
        return {power_not_good_flag, off, overcurrent_flag, uv, t};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_set();
        chk("settings", {6'h0, st[0], st[1], st[2][2:0], st[3][2:0]},
            {6'h0, ch1, ch2, t1, t2});
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // A bound that runs out ends the run, since later steps would hang.
    task automatic wait_att(input logic e);
        int k;
        k = 0;
        while (att_oe !== e && k < 20) begin
            cyc(1);
            k++;
        end
        chk("attention", {23'h0, e}, {22'h0, att_out, att_oe});
        if (att_oe !== e) tally_and_finish();
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        u_master.start();
        u_master.xfer9({a, 1'b0, 1'b1}, rx);
        ak[1] = ~rx[0];
        // master leaves the ack slot released
        u_master.xfer9({v, 1'b1}, rx);
        ak[0] = ~rx[0];
        u_master.stop();
    endtask

    task automatic rd(input logic [6:0] a, input int n);
        u_master.start();
        u_master.xfer9({a, 1'b1, 1'b1}, rx);
        ack = ~rx[0];
        for (int i = 0; i < n; i++) begin
            // master acks all but the last byte
            u_master.xfer9({8'hff, i == n - 1}, rx);
            rb[i] = rx[8:1];
        end
        u_master.stop();
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        {reset_n, ot, overcurrent_flag, off, power_not_good_flag, cad, tone} = '0;
        {logic_ok, main_ok} = 2'b11;
        st = '{default: 6'h00};
        seed = xs(32'h0001_1d14);
        bus_id = seed[1:0];
        addr = {ADDR_FIXED_HI, bus_id};
        cyc(10);
        reset_n = 1'b1;
        cyc(10);
        chk_set(); // zero after power-up
        wait_att(1'b1); // power-on attention
        for (int i = 0; i < 7; i++) begin
            wr(addr ^ (7'h01 << i), 8'h3f);
            chk("foreign ack", 24'h0, {22'h0, ak}); // no ack
        end
        chk_set(); // nothing stored
        wait_att(1'b1); // writes keep attention
        rd(addr, 3);
        chk("read ack", 24'h1, {22'h0, sda_out, ack}); // address ack
        wait_att(1'b0); // read clears attention
        chk("first read", 24'h02_0002, {rb[0], rb[1], rb[2]});
        rd(addr, 1);
        chk("healthy", 24'h0, {16'h0, rb[0]}); // cleared
        seed = xs(seed);
        {off, power_not_good_flag, cad, tone} = seed[7:0];
        cyc(20);
        chk("live quiet", 24'h0, {23'h0, att_oe}); // no attention
        rd(addr, 2);
        chk("live", {8'h0, exp_s1(0, 0), 4'h0, tone, cad},
            {8'h0, rb[0], rb[1]}); // live flags
        for (int i = 0; i < 3; i++) begin
            {overcurrent_flag, ot} = 3'h1 << i;
            wait_att(1'b1); // fault raises attention
            {overcurrent_flag, ot} = 3'h0;
            cyc(8);
            rd(addr, 1);
            d = (i == 0) ? 8'h01 : (8'h02 << i);
            chk("latched", {16'h0, exp_s1(0, 0) | d},
                {16'h0, rb[0]}); // held
            rd(addr, 1);
            chk("resampled", {16'h0, exp_s1(0, 0)}, {16'h0, rb[0]});
        end
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            d = {i[1:0], seed[5:0]};
            st[i[1:0]] = seed[5:0];
            wr(addr, d);
            chk("write ack", 24'h3, {22'h0, ak}); // acked
            chk_set(); // stored fields
        end
        u_master.start();
        u_master.xfer9({addr, 1'b0, 1'b1}, rx);
        u_master.xfer9({SEL_CHAN1_OUTPUT, 6'h15, 1'b1}, rx);
        u_master.xfer9({SEL_CHAN2_OUTPUT, 6'h2a, 1'b1}, rx);
        chk("extra byte", 24'h1, {23'h0, rx[0]}); // refused
        u_master.stop();
        st[0] = 6'h15;
        chk_set(); // second byte dropped
        u_master.start();
        u_master.xfer9({addr, 1'b0, 1'b1}, rx);
        u_master.start();
        u_master.xfer9({SEL_CHAN1_OUTPUT, 6'h3f, 1'b1}, rx);
        chk("abort", 24'h1, {23'h0, rx[0]}); // restart as address
        u_master.stop();
        chk_set(); // nothing stored
        logic_ok = 1'b0;
        cyc(6);
        wr(addr, 8'h3f);
        chk("supply low", 24'h0, {22'h0, ak}); // bus ignored
        logic_ok = 1'b1;
        wait_att(1'b1); // attention again
        cyc(6);
        rd(addr, 1);
        chk("undervoltage", {16'h0, exp_s1(1, 0)}, {16'h0, rb[0]});
        tally_and_finish();
    end
endmodule

`default_nettype wire
